// File: hw/doc_out_chan.sv
// digital output channel processing with apb registers and watchdog
`timescale 1ns/1ps
`include "doc_defs.svh"
// Contract
// - three failures then 500 ms: outputs off
// - normal mode drives received bus value
// - simulation mode drives configured simulated value
// - watchdog expiry or invalid data: error behaviour
// - line faults never start substitute behaviour
// - current value setting forwards incoming signal
// - substitute setting drives configured substitute bit
// - last valid setting holds pre-fault value
// - inversion option flips the output level
// - on delay filters short high pulses
// - channel activity follows module active bit
// - off delay filters short low pulses
// - substitute value reports invalid data status
// - invalid simulation status starts error behaviour
module doc_out_chan #(
  parameter int MS_CYCLES = `DOC_MS_NS / `DOC_CLK_NS
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`DOC_AW-1:0]     paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // output channels
  output logic [`DOC_NCH-1:0]         chan_out,
  output logic [`DOC_NCH-1:0]         chan_invalid,
  // interrupt
  output logic                        irq
);
  // ==========================================
  // register state
  logic                      active_reg;    // module active
  logic [`DOC_NCH-1:0]       bus_val_reg;   // values from the com unit
  logic [`DOC_NCH-1:0]       bus_inv_reg;   // invalid flags from the com unit
  doc_pkg::doc_chcfg_t       cfg_reg [`DOC_NCH];
  doc_pkg::doc_chdly_t       dly_reg [`DOC_NCH];
  logic [`DOC_IRQ_W-1:0]     istat_reg;     // sticky events
  logic [`DOC_IRQ_W-1:0]     imask_reg;     // interrupt enables
  logic [`DOC_IRQ_W-1:0]     istat_next;
  logic [31:0]               rd_reg;        // read data, loaded in setup
  logic                      err_reg;       // unmapped address seen in setup

  // ==========================================
  // bus decode
  wire                 setup_ph = psel && !penable;
  wire                 wr_acc   = psel && penable && pwrite;
  wire [`DOC_AW-1:0]   bank     = paddr & `DOC_A_BANKMSK;
  wire [1:0]           idx      = paddr[3:2];
  wire                 hit_ctrl = (paddr == `DOC_A_CTRL);
  wire                 hit_bus  = (paddr == `DOC_A_BUSDATA);
  wire                 hit_comm = (paddr == `DOC_A_COMM);
  wire                 hit_stat = (paddr == `DOC_A_STATUS);
  wire                 hit_ist  = (paddr == `DOC_A_ISTAT);
  wire                 hit_imk  = (paddr == `DOC_A_IMASK);
  wire                 hit_cfg  = (bank == `DOC_A_CHCFG) && (paddr[1:0] == 2'h0);
  wire                 hit_dly  = (bank == `DOC_A_CHDLY) && (paddr[1:0] == 2'h0);
  wire                 mapped   = hit_ctrl | hit_bus | hit_comm | hit_stat |
                                  hit_ist | hit_imk | hit_cfg | hit_dly;
  wire                 comm_ok   = wr_acc && hit_comm && pwdata[`DOC_COMM_OK];
  wire                 comm_fail = wr_acc && hit_comm && pwdata[`DOC_COMM_FAIL];

  // zero wait state slave
  assign pready  = 1'b1;
  assign prdata  = rd_reg;
  assign pslverr = psel && penable && err_reg;

  // ==========================================
  // millisecond timebase
  logic ms_tick;
  doc_ms_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clk   (clk),
    .reset (reset),
    .tick  (ms_tick)
  );

  // ==========================================
  // watchdog: failures counted until a good exchange
  doc_pkg::doc_wdst_t wd_reg;       // watchdog state
  doc_pkg::doc_wdst_t wd_next;
  logic [1:0]         fails_reg;    // consecutive failures
  logic [9:0]         wd_ms_reg;    // ms spent armed
  wire                fails_hit = comm_fail && (fails_reg == `DOC_WD_FAILS - 2'd1);
  wire                wd_expire = ms_tick && (wd_ms_reg == 10'(`DOC_WD_MS - 1));
  wire                wd_off    = (wd_reg == doc_pkg::DOC_WD_OFF);

  // next watchdog state; a good exchange wins over a failure
  always_comb
  begin
    wd_next = wd_reg;
    unique case (wd_reg)
      doc_pkg::DOC_WD_OK:
        if (!comm_ok && fails_hit)
          wd_next = doc_pkg::DOC_WD_ARMED;
      doc_pkg::DOC_WD_ARMED:
        if (comm_ok)
          wd_next = doc_pkg::DOC_WD_OK;
        else if (wd_expire)
          wd_next = doc_pkg::DOC_WD_OFF;
      doc_pkg::DOC_WD_OFF:
        if (comm_ok)
          wd_next = doc_pkg::DOC_WD_OK;
      default:
        wd_next = doc_pkg::DOC_WD_OK;
    endcase
  end

  // watchdog registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wd_reg    <= doc_pkg::DOC_WD_OK;
      fails_reg <= 2'h0;
      wd_ms_reg <= 10'h0;
    end
    else
    begin
      wd_reg <= wd_next;
      if (comm_ok)
        fails_reg <= 2'h0;
      else if (comm_fail && fails_reg != `DOC_WD_FAILS)
        fails_reg <= fails_reg + 2'h1;
      // ms counter runs only while armed
      if (wd_reg != doc_pkg::DOC_WD_ARMED)
        wd_ms_reg <= 10'h0;
      else if (ms_tick)
        wd_ms_reg <= wd_ms_reg + 10'h1;
    end
  end

  // ==========================================
  // channel processing
  logic [`DOC_NCH-1:0] src_val;   // bus or simulated value
  logic [`DOC_NCH-1:0] ch_err;    // channel in error behaviour
  logic [`DOC_NCH-1:0] sel_val;   // after error behaviour
  logic [`DOC_NCH-1:0] want;      // after inversion, before delays
  logic [`DOC_NCH-1:0] dly_out;   // after delays
  logic [`DOC_NCH-1:0] last_reg;  // last value seen without error
  logic [`DOC_NCH-1:0] out_reg;   // driven outputs
  logic [`DOC_NCH-1:0] inv_reg;   // reported data status
  logic [`DOC_NCH-1:0] err_d_reg; // previous error, for event edge
  logic [`DOC_NCH-1:0] subst_on;  // substitute currently chosen

  genvar gi;
  generate
    for (gi = 0; gi < `DOC_NCH; gi++)
    begin : g_ch
      wire sim = cfg_reg[gi].sim_mode;
      wire src_inv = sim ? cfg_reg[gi].sim_invalid : bus_inv_reg[gi];
      wire is_cur  = (cfg_reg[gi].err_mode == doc_pkg::DOC_ERR_CURRENT);
      wire is_sub  = (cfg_reg[gi].err_mode == doc_pkg::DOC_ERR_SUBST);
      // simulated value replaces the bus value
      assign src_val[gi] = sim ? cfg_reg[gi].sim_val : bus_val_reg[gi];
      // only watchdog and invalid status count; no line fault input exists
      assign ch_err[gi]  = wd_off | src_inv;
      assign subst_on[gi] = ch_err[gi] && is_sub;
      // unknown mode codes act as current value
      assign sel_val[gi] = !ch_err[gi] ? src_val[gi] :
                           is_sub      ? cfg_reg[gi].subst_val :
                           is_cur      ? src_val[gi] :
                           (cfg_reg[gi].err_mode == doc_pkg::DOC_ERR_LAST) ?
                                         last_reg[gi] :
                                         src_val[gi];
      assign want[gi] = sel_val[gi] ^ cfg_reg[gi].invert;

      doc_chan_delay u_dly (
        .clk    (clk),
        .reset  (reset || !active_reg),
        .tick   (ms_tick),
        .din    (want[gi]),
        .on_ms  (dly_reg[gi].on_ms),
        .off_ms (dly_reg[gi].off_ms),
        .dout   (dly_out[gi])
      );

      a_norm_pass: assert property (@(posedge clk) disable iff (reset)
        (!sim && !ch_err[gi]) |-> (sel_val[gi] == bus_val_reg[gi]))
        else $error("normal mode value not taken from bus");
      a_sim_pass: assert property (@(posedge clk) disable iff (reset)
        (sim && !ch_err[gi]) |-> (sel_val[gi] == cfg_reg[gi].sim_val))
        else $error("simulated value not used");
      a_sim_invalid: assert property (@(posedge clk) disable iff (reset)
        (sim && cfg_reg[gi].sim_invalid) |-> ch_err[gi])
        else $error("invalid simulation status ignored");
      a_subst_stat: assert property (@(posedge clk) disable iff (reset)
        (ch_err[gi] && is_sub) |=> (inv_reg[gi] && $past(sel_val[gi]) ==
          $past(cfg_reg[gi].subst_val)))
        else $error("substitute not driven as invalid");
      a_last_hold: assert property (@(posedge clk) disable iff (reset)
        ($rose(ch_err[gi]) && cfg_reg[gi].err_mode == doc_pkg::DOC_ERR_LAST &&
          $stable(cfg_reg[gi])) |-> (sel_val[gi] == $past(src_val[gi])))
        else $error("last valid value lost");
      // current value mode keeps forwarding the raw incoming level, bus or simulated
      a_cur_pass: assert property (@(posedge clk) disable iff (reset)
        (ch_err[gi] && is_cur) |->
          (sel_val[gi] == (sim ? cfg_reg[gi].sim_val : bus_val_reg[gi])))
        else $error("current value not forwarded in error");
    end
  endgenerate

  // ==========================================
  // output stage; active bit and watchdog gate every channel
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_reg   <= '0;
      inv_reg   <= '0;
      last_reg  <= '0;
      err_d_reg <= '0;
    end
    else
    begin
      out_reg   <= (active_reg && !wd_off) ? dly_out : '0;
      inv_reg   <= subst_on;
      last_reg  <= (last_reg & ch_err) | (src_val & ~ch_err);
      err_d_reg <= ch_err;
    end
  end

  assign chan_out     = out_reg;
  assign chan_invalid = inv_reg;

  // ==========================================
  // interrupts: set wins over a write-one clear
  wire [`DOC_IRQ_W-1:0] ev;
  wire [`DOC_IRQ_W-1:0] w1c = (wr_acc && hit_ist) ? pwdata[`DOC_IRQ_W-1:0] : '0;
  assign ev[`DOC_IRQ_WD]  = (wd_reg == doc_pkg::DOC_WD_ARMED) && wd_expire && !comm_ok;
  assign ev[`DOC_IRQ_ERR] = |(ch_err & ~err_d_reg);
  assign ev[`DOC_IRQ_CHG] = |(out_reg ^ ((active_reg && !wd_off) ? dly_out : '0));
  assign istat_next = (istat_reg & ~w1c) | ev;
  assign irq = |(istat_reg & imask_reg);

  // ==========================================
  // read mux, sampled in the setup cycle
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0;
    if (hit_ctrl)
      rd_mux[`DOC_CTRL_ACT] = active_reg;
    else if (hit_bus)
    begin
      rd_mux[`DOC_NCH-1:0] = bus_val_reg;
      rd_mux[`DOC_INV_LSB +: `DOC_NCH] = bus_inv_reg;
    end
    else if (hit_stat)
    begin
      rd_mux[`DOC_NCH-1:0] = out_reg;
      rd_mux[`DOC_INV_LSB +: `DOC_NCH] = inv_reg;
      rd_mux[`DOC_STAT_WD] = wd_off;
    end
    else if (hit_ist)
      rd_mux[`DOC_IRQ_W-1:0] = istat_reg;
    else if (hit_imk)
      rd_mux[`DOC_IRQ_W-1:0] = imask_reg;
    else if (hit_cfg)
      rd_mux[$bits(doc_pkg::doc_chcfg_t)-1:0] = cfg_reg[idx];
    else if (hit_dly)
      rd_mux = dly_reg[idx];
  end

  // ==========================================
  // register writes at the access edge
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      active_reg  <= `DOC_CTRL_RST;
      bus_val_reg <= '0;
      bus_inv_reg <= '0;
      istat_reg   <= '0;
      imask_reg   <= '0;
      rd_reg      <= 32'h0;
      err_reg     <= 1'b0;
      for (int k = 0; k < `DOC_NCH; k++)
      begin
        cfg_reg[k] <= `DOC_CFG_RST;
        dly_reg[k] <= `DOC_DLY_RST;
      end
    end
    else
    begin
      istat_reg <= istat_next;
      if (setup_ph)
      begin
        rd_reg  <= pwrite ? 32'h0 : rd_mux;
        err_reg <= !mapped;
      end
      if (wr_acc && hit_ctrl)
        active_reg <= pwdata[`DOC_CTRL_ACT];
      if (wr_acc && hit_bus)
      begin
        bus_val_reg <= pwdata[`DOC_NCH-1:0];
        bus_inv_reg <= pwdata[`DOC_INV_LSB +: `DOC_NCH];
      end
      if (wr_acc && hit_imk)
        imask_reg <= pwdata[`DOC_IRQ_W-1:0];
      if (wr_acc && hit_cfg)
        cfg_reg[idx] <= pwdata[$bits(doc_pkg::doc_chcfg_t)-1:0];
      if (wr_acc && hit_dly)
        dly_reg[idx] <= pwdata;
    end
  end

  // ==========================================
  // checks
  a_wd_off_out: assert property (@(posedge clk) disable iff (reset)
    (wd_off && $past(wd_off)) |-> (out_reg == '0))
    else $error("outputs on after watchdog trip");
  a_wd_trip_time: assert property (@(posedge clk) disable iff (reset)
    $rose(wd_off) |-> ($past(wd_ms_reg) == 10'(`DOC_WD_MS - 1) && $past(ms_tick)))
    else $error("watchdog tripped at wrong time");
  a_wd_arm: assert property (@(posedge clk) disable iff (reset)
    (wd_reg == doc_pkg::DOC_WD_OK && fails_hit && !comm_ok)
      |=> (wd_reg == doc_pkg::DOC_WD_ARMED && wd_ms_reg == 10'h0))
    else $error("watchdog not armed on third failure");
  a_inactive_off: assert property (@(posedge clk) disable iff (reset)
    !active_reg |=> (out_reg == '0))
    else $error("inactive module drives outputs");
  a_reset_off: assert property (@(posedge clk)
    reset |=> (out_reg == '0 && inv_reg == '0))
    else $error("outputs not off after reset");
  // a trip must latch even when software clears the same bit in that cycle
  a_wd_irq_set: assert property (@(posedge clk) disable iff (reset)
    ev[`DOC_IRQ_WD] |=> istat_reg[`DOC_IRQ_WD])
    else $error("watchdog event lost");
  // a channel entering error behaviour is latched the same way
  a_err_irq_set: assert property (@(posedge clk) disable iff (reset)
    ev[`DOC_IRQ_ERR] |=> istat_reg[`DOC_IRQ_ERR])
    else $error("channel error event lost");
endmodule : doc_out_chan

// File: hw/doc_defs.svh
// constants for the digital output channel block
`ifndef DOC_DEFS_SVH
`define DOC_DEFS_SVH
// ==========================================
// sizes and timing
`define DOC_NCH        4
`define DOC_CLK_NS     10
`define DOC_MS_NS      1000000
`define DOC_WD_MS      500
`define DOC_WD_FAILS   2'd3
`define DOC_AW         12
// ==========================================
// register byte offsets
`define DOC_A_CTRL     12'h000
`define DOC_A_BUSDATA  12'h004
`define DOC_A_COMM     12'h008
`define DOC_A_STATUS   12'h00c
`define DOC_A_ISTAT    12'h010
`define DOC_A_IMASK    12'h014
`define DOC_A_CHCFG    12'h020
`define DOC_A_CHDLY    12'h040
`define DOC_A_BANKMSK  12'hff0
// ==========================================
// field positions
`define DOC_CTRL_ACT   0
`define DOC_COMM_OK    0
`define DOC_COMM_FAIL  1
`define DOC_INV_LSB    8
`define DOC_STAT_WD    16
`define DOC_IRQ_WD     0
`define DOC_IRQ_ERR    1
`define DOC_IRQ_CHG    2
`define DOC_IRQ_W      3
// ==========================================
// reset values
`define DOC_CTRL_RST   1'b1
`define DOC_CFG_RST    7'h00
`define DOC_DLY_RST    32'h0000_0000
`endif

// File: hw/doc_pkg.sv
// types shared by the digital output channel block
package doc_pkg;
  // ==========================================
  // error behaviour choice
  typedef enum logic [1:0] {
    DOC_ERR_CURRENT = 2'h0,
    DOC_ERR_SUBST   = 2'h1,
    DOC_ERR_LAST    = 2'h2
  } doc_errmode_t;

  // per channel configuration word, low bits of the config register
  typedef struct packed {
    logic         invert;
    logic         subst_val;
    doc_errmode_t err_mode;
    logic         sim_invalid;
    logic         sim_val;
    logic         sim_mode;
  } doc_chcfg_t;

  // per channel delays in ms
  typedef struct packed {
    logic [15:0] off_ms;
    logic [15:0] on_ms;
  } doc_chdly_t;

  // watchdog states
  typedef enum logic [2:0] {
    DOC_WD_OK    = 3'b001,
    DOC_WD_ARMED = 3'b010,
    DOC_WD_OFF   = 3'b100
  } doc_wdst_t;
endpackage : doc_pkg

// File: hw/doc_ms_tick.sv
// millisecond tick generator from the module clock
`timescale 1ns/1ps
`include "doc_defs.svh"
module doc_ms_tick #(
  parameter int MS_CYCLES = `DOC_MS_NS / `DOC_CLK_NS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // one cycle pulse per ms
  output logic      tick
);
  logic [31:0] cnt_reg;   // cycles within the current ms
  logic        last_cyc;  // final cycle of the ms

  assign last_cyc = (cnt_reg == 32'(MS_CYCLES - 1));
  assign tick     = last_cyc;

  // ==========================================
  // free running divider
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_reg <= 32'h0;
    else if (last_cyc)
      cnt_reg <= 32'h0;
    else
      cnt_reg <= cnt_reg + 32'h1;
  end
endmodule : doc_ms_tick

// File: hw/doc_chan_delay.sv
// on and off delay of one output channel, counted in ms ticks
`timescale 1ns/1ps
`include "doc_defs.svh"
module doc_chan_delay (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        tick,
  // wanted level and delays
  input  wire logic        din,
  input  wire logic [15:0] on_ms,
  input  wire logic [15:0] off_ms,
  // delayed level
  output logic             dout
);
  logic        out_reg;   // delayed level, off after reset
  logic [15:0] cnt_reg;   // ms elapsed since the input differed
  logic [15:0] cnt_inc;   // count after this tick
  logic [15:0] need;      // delay for the pending change
  logic        done;      // pending change may pass

  assign cnt_inc = cnt_reg + 16'h1;
  assign need    = din ? on_ms : off_ms;
  // a zero delay passes at once; otherwise wait for whole ticks
  assign done    = (need == 16'h0) || (tick && (cnt_inc >= need));
  assign dout    = out_reg;

  // ==========================================
  // a change that reverts before its delay is dropped
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      out_reg <= 1'b0;
      cnt_reg <= 16'h0;
    end
    else if (din == out_reg)
      cnt_reg <= 16'h0;
    else if (done)
    begin
      out_reg <= din;
      cnt_reg <= 16'h0;
    end
    else if (tick)
      cnt_reg <= cnt_inc;
  end

  // ==========================================
  // checks
  a_on_hold: assert property (@(posedge clk) disable iff (reset)
    (din && !out_reg && cnt_reg == 16'h0 && on_ms > 16'h1 && on_ms == $past(on_ms))
      |=> !out_reg) else $error("rising edge passed before on delay");
  a_off_hold: assert property (@(posedge clk) disable iff (reset)
    (!din && out_reg && cnt_reg == 16'h0 && off_ms > 16'h1 && off_ms == $past(off_ms))
      |=> out_reg) else $error("falling edge passed before off delay");
endmodule : doc_chan_delay

// File: tb/doc_com_unit.sv
// apb master model of the communication unit that feeds the channel block
`timescale 1ns/1ps
`include "doc_defs.svh"
module doc_com_unit (
  // clock
  input  wire logic               clk,
  // apb answer
  input  wire logic               pready,
  input  wire logic [31:0]        prdata,
  input  wire logic               pslverr,
  // apb request
  output logic                    psel,
  output logic                    penable,
  output logic                    pwrite,
  output logic [`DOC_AW-1:0]      paddr,
  output logic [31:0]             pwdata,
  // raised when an answer never came
  output logic                    hung
);
  // ==========================================
  // idle bus at time zero
  // no line fault path exists on this side at all
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    hung    = 1'b0;
  end

  // ==========================================
  // one transfer: setup cycle, then access held until pready at an edge
  task automatic xfer(input logic wr, input logic [`DOC_AW-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      // wait for pready, bounded so a dead slave cannot hang us
      do
      begin
        @(posedge clk);
        n++;
      end
      while (pready !== 1'b1 && n < 50);
      hung    <= (n >= 50);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer
endmodule : doc_com_unit

// File: tb/test_digital_output_channel_processing.sv
// self-checking bench for the digital output channel block
`timescale 1ns/1ps
`include "doc_defs.svh"
module test_digital_output_channel_processing;
  // ==========================================
  // signals
  localparam int MSC = 10;                // short ms so the run stays brief
  logic                   clk;
  logic                   reset;
  logic                   psel, penable, pwrite, pready, pslverr, irq, hung;
  logic [`DOC_AW-1:0]     paddr;
  logic [31:0]            pwdata, prdata, rdv;
  logic                   erv;
  logic [`DOC_NCH-1:0]    chan_out, chan_invalid;
  int                     mismatches;
  int                     n_compared;

  // ==========================================
  // design and communication unit model
  doc_out_chan #(.MS_CYCLES(MSC)) uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .chan_out(chan_out), .chan_invalid(chan_invalid),
    .irq(irq));
  doc_com_unit com (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .hung(hung));

  // clock at 100 MHz
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  task automatic rd(input logic [`DOC_AW-1:0] a);
    com.xfer(1'b0, a, 32'h0000_0000, rdv, erv);
    @(posedge clk);
    if (hung === 1'b1)
    begin
      mismatches++;
      end_sim();
    end
  endtask : rd

  task automatic wr(input logic [`DOC_AW-1:0] a, input logic [31:0] d);
    com.xfer(1'b1, a, d, rdv, erv);
    @(posedge clk);
    if (hung === 1'b1)
    begin
      mismatches++;
      end_sim();
    end
  endtask : wr

  // reset held 8 cycles, each scenario starts clean
  task automatic rst;
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask : rst

  // ==========================================
  // scenarios
  task automatic t_reset;
    rst();
    chk(chan_out, 4'h0);
    chk(irq, 1'b0);
    rd(`DOC_A_CTRL);
    chk(rdv, 32'h0000_0001);
    rd(12'h0fc);                                           // unmapped place
    chk(erv, 1'b1);
    chk(rdv, 32'h0000_0000);
  endtask : t_reset

  task automatic t_modes;
    rst();
    wr(`DOC_A_BUSDATA, 32'h0000_0005);
    repeat (4) @(posedge clk);
    chk(chan_out, 4'h5);
    wr(`DOC_A_CHCFG, 32'h0000_0040);                       // invert ch0
    wr(`DOC_A_CHCFG + 12'h004, 32'h0000_0003);             // ch1 simulated 1
    repeat (4) @(posedge clk);
    chk(chan_out, 4'h6);
    wr(`DOC_A_CTRL, 32'h0000_0000);
    repeat (4) @(posedge clk);
    chk(chan_out, 4'h0);
    wr(`DOC_A_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(chan_out, 4'h6);
  endtask : t_modes

  task automatic t_errors;
    rst();
    wr(`DOC_A_CHCFG, 32'h0000_0018);                       // code 3 acts as current
    wr(`DOC_A_CHCFG + 12'h004, 32'h0000_0028);             // substitute 1
    wr(`DOC_A_CHCFG + 12'h008, 32'h0000_0010);             // last valid
    wr(`DOC_A_CHCFG + 12'h00c, 32'h0000_002d);             // sim invalid, subst 1
    wr(`DOC_A_BUSDATA, 32'h0000_0007);
    repeat (4) @(posedge clk);
    chk({chan_invalid, chan_out}, 8'h8f);
    wr(`DOC_A_BUSDATA, 32'h0000_0700);                     // values 0, ch0..2 invalid
    repeat (4) @(posedge clk);
    chk({chan_invalid, chan_out}, 8'hae);
    rd(`DOC_A_STATUS);
    chk(rdv, 32'h0000_0a0e);
    rd(`DOC_A_ISTAT);
    chk(rdv, 32'h0000_0006);
  endtask : t_errors

  task automatic t_delay;
    rst();
    wr(`DOC_A_CHDLY, 32'h0003_0003);                       // 3 ms on and off
    rd(`DOC_A_CHDLY);
    chk(rdv, 32'h0003_0003);
    wr(`DOC_A_BUSDATA, 32'h0000_0001);
    repeat (12) @(posedge clk);
    wr(`DOC_A_BUSDATA, 32'h0000_0000);
    repeat (40) @(posedge clk);
    chk(chan_out, 4'h0);
    wr(`DOC_A_BUSDATA, 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk(chan_out, 4'h1);
    wr(`DOC_A_BUSDATA, 32'h0000_0000);
    repeat (12) @(posedge clk);
    chk(chan_out, 4'h1);
    repeat (30) @(posedge clk);
    chk(chan_out, 4'h0);
  endtask : t_delay

  task automatic t_watchdog;
    rst();
    wr(`DOC_A_BUSDATA, 32'h0000_000f);
    wr(`DOC_A_IMASK, 32'h0000_0001);
    // two failures then a good exchange must not arm
    wr(`DOC_A_COMM, 32'h0000_0002);
    wr(`DOC_A_COMM, 32'h0000_0002);
    wr(`DOC_A_COMM, 32'h0000_0003);                        // good wins over fail
    repeat (3) wr(`DOC_A_COMM, 32'h0000_0002);
    repeat (4940) @(posedge clk);
    chk({irq, chan_out}, 5'h0f);
    repeat (80) @(posedge clk);
    chk({irq, chan_out}, 5'h10);
    rd(`DOC_A_STATUS);
    chk(rdv[16], 1'b1);
    wr(`DOC_A_ISTAT, 32'h0000_0001);
    chk(irq, 1'b0);
    wr(`DOC_A_COMM, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk(chan_out, 4'hf);
  endtask : t_watchdog

  // ==========================================
  // main sequence
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    reset      = 1'b1;
    t_reset();
    t_modes();
    t_errors();
    t_delay();
    t_watchdog();
    end_sim();
  end

  // run limit against a hang
  initial
  begin
    repeat (100000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : test_digital_output_channel_processing
